/* File: hdl/nst_pkg.sv */
// constants and types shared by the nibble swap / table access execution block
// assumes a single 100 MHz core clock and active-low asynchronous reset
package nst_pkg;
  // instruction word and field layout
  localparam int          NST_IW          = 16;
  localparam int          NST_PW          = 21;
  localparam logic [5:0]  NST_SWAP_OP     = 6'h0E;   // 0011 10da
  localparam logic [13:0] NST_TBL_PREFIX  = 14'h0002;  // 0000 0000 0000 1x
  localparam int          NST_TBL_WR_BIT  = 2;
  localparam int          NST_D_BIT       = 9;
  localparam int          NST_A_BIT       = 8;
  // indexed literal offset limit (95)
  localparam logic [7:0]  NST_IDX_LIMIT   = 8'h5F;
  // access bank split: low half below 0x60, upper half maps to bank 0xF
  localparam logic [3:0]  NST_ACC_HI_BANK = 4'hF;
  // pointer modes
  localparam logic [1:0]  NST_M_NONE      = 2'h0;
  localparam logic [1:0]  NST_M_POSTINC   = 2'h1;
  localparam logic [1:0]  NST_M_POSTDEC   = 2'h2;
  localparam logic [1:0]  NST_M_PREINC    = 2'h3;
  // holding register count and reset values
  localparam int          NST_HOLD_N      = 8;
  localparam logic [20:0] NST_PTR_RST     = 21'h000000;
  localparam logic [7:0]  NST_BYTE_RST    = 8'h00;
  localparam logic [7:0]  NST_HOLD_RST    = 8'hFF;
  // fifo shape
  localparam int          NST_FIFO_W      = 16;
  localparam int          NST_FIFO_D      = 16;
  // four core clocks per instruction cycle
  localparam logic [1:0]  NST_Q_LAST      = 2'h3;
  // exec state machine, one-hot
  typedef enum logic [3:0] {
    NST_IDLE  = 4'b0001,
    NST_EXEC  = 4'b0010,
    NST_TBL2  = 4'b0100,
    NST_DONE  = 4'b1000
  } nst_state_e;
endpackage

/* File: hdl/nst_fifo.sv */
// parameterised instruction word fifo with valid/ready on both sides
// assumes both sides on core_clk
module nst_fifo
  import nst_pkg::*;
#(
  parameter int W = NST_FIFO_W,
  parameter int D = NST_FIFO_D
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];          // storage
  logic [AW-1:0] wr_ptr;          // write index
  logic [AW-1:0] rd_ptr;          // read index
  logic [AW:0]   count;           // fill level
  wire           do_wr = in_valid && in_ready;
  wire           do_rd = out_valid && out_ready;
  wire [AW:0]    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);  // level after this edge
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  // storage write, no reset needed
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // pointers and level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      // registered full test so the upstream ready comes from a flop
      in_ready <= (next_count != (AW+1)'(D));
    end
  end
endmodule // nst_fifo

/* File: hdl/nst_addr.sv */
// file address resolution: access bank, banked, or indexed literal offset
// assumes combinational use inside the exec block
module nst_addr
  import nst_pkg::*;
(
  // operand
  input  wire logic [7:0]  file_addr,
  input  wire logic        access_sel,
  // context
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_ptr,
  // resolved 12-bit data address
  output logic [11:0]      data_addr
);
  wire idx_mode  = ext_set_en && !access_sel && (file_addr <= NST_IDX_LIMIT);
  wire [11:0] idx_addr  = index_ptr + {4'h0, file_addr};
  wire [11:0] acc_addr  = (file_addr <= NST_IDX_LIMIT) ? {4'h0, file_addr}
                                                        : {NST_ACC_HI_BANK, file_addr};
  wire [11:0] bank_addr = {bank_select_reg, file_addr};
  // select path by access bit
  assign data_addr = idx_mode ? idx_addr : (access_sel ? bank_addr : acc_addr);
endmodule // nst_addr

/* File: hdl/nst_exec.sv */
// execution of nibble swap, table read and table write
// assumes words arrive on a valid/ready stream, data and program memory answer
// one core clock after their request
//
// Behaviour
// - swap writes nibbles exchanged to destination
// - dest bit 0 to working reg else file
// - access bit picks access bank or banked
// - bank select reg selects general purpose bank
// - extended set: low addresses index from pointer
// - swap keeps flags, one instruction cycle
// - table read loads latch from program memory
// - pointer is 21-bit byte address
// - pointer bit zero picks low/high byte
// - mode field: none, post inc, post dec, pre inc
// - table read takes two instruction cycles
// - table write fills holding register, not array
module nst_exec
  import nst_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // instruction stream
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire logic [NST_IW-1:0] instr_word,
  // configuration
  input  wire logic [3:0]        bank_select_reg,
  input  wire logic              ext_set_en,
  input  wire logic [11:0]       index_ptr,
  // data memory read
  output logic                   dmem_rd,
  output logic [11:0]            dmem_addr,
  input  wire logic [7:0]        dmem_rdata,
  // data memory / working register write
  output logic                   dmem_wr,
  output logic [7:0]             dmem_wdata,
  output logic                   wreg_wr,
  output logic [7:0]             wreg_wdata,
  // program memory read
  output logic                   pmem_rd,
  output logic [NST_PW-2:0]      pmem_word_addr,
  input  wire logic [15:0]       pmem_rdata,
  // status
  output logic [NST_PW-1:0]      table_pointer,
  output logic [7:0]             table_latch,
  output logic [NST_HOLD_N*8-1:0] hold_regs,
  output logic                   busy,
  output logic                   instr_done
);
  nst_state_e   state;                // current state
  nst_state_e   next_state;           // next state
  logic [1:0]   qph;                  // phase within instruction cycle
  logic [NST_IW-1:0] cur;             // word under execution
  logic         cyc2;                 // in second instruction cycle
  // fifo drain side
  logic              f_valid;
  logic [NST_IW-1:0] f_data;
  wire               f_take = (state == NST_IDLE) && f_valid;

  nst_fifo #(.W(NST_FIFO_W), .D(NST_FIFO_D)) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (instr_valid),
    .in_ready  (instr_ready),
    .in_data   (instr_word),
    .out_valid (f_valid),
    .out_ready (f_take),
    .out_data  (f_data)
  );

  // decode of the held word
  wire is_swap   = (cur[15:10] == NST_SWAP_OP);
  wire is_tbl    = (cur[15:3] == NST_TBL_PREFIX[13:1]);
  wire is_tblwr  = is_tbl && cur[NST_TBL_WR_BIT];
  wire is_table_read_op  = is_tbl && !cur[NST_TBL_WR_BIT];
  wire [1:0] mode = cur[1:0];
  wire to_file   = cur[NST_D_BIT];
  wire q_end     = (qph == NST_Q_LAST);

  // address resolution for the swap operand
  logic [11:0] res_addr;
  nst_addr u_addr (
    .file_addr       (cur[7:0]),
    .access_sel      (cur[NST_A_BIT]),
    .bank_select_reg (bank_select_reg),
    .ext_set_en      (ext_set_en),
    .index_ptr       (index_ptr),
    .data_addr       (res_addr)
  );

  // pointer arithmetic wraps in 21 bits
  wire [NST_PW-1:0] ptr_inc  = table_pointer + 21'h000001;
  wire [NST_PW-1:0] ptr_dec  = table_pointer - 21'h000001;
  wire [NST_PW-1:0] acc_ptr  = (mode == NST_M_PREINC) ? ptr_inc : table_pointer;
  wire [NST_PW-1:0] next_ptr = (mode == NST_M_NONE)    ? table_pointer :
                               (mode == NST_M_POSTDEC) ? ptr_dec : ptr_inc;
  // byte from program word by pointer bit zero
  wire [7:0] pm_byte = acc_ptr[0] ? pmem_rdata[15:8] : pmem_rdata[7:0];
  wire [7:0] swapped = {dmem_rdata[3:0], dmem_rdata[7:4]};
  wire [2:0] hold_sel = acc_ptr[2:0];

  // state sequencing: swap one cycle, table ops two
  always_comb begin
    next_state = state;
    unique case (state)
      NST_IDLE: if (f_valid) next_state = NST_EXEC;
      NST_EXEC: if (q_end) next_state = (is_tbl ? NST_TBL2 : NST_DONE);
      NST_TBL2: if (q_end) next_state = NST_DONE;
      NST_DONE: next_state = NST_IDLE;
      default:  next_state = NST_IDLE;
    endcase
  end

  // state register and phase counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= NST_IDLE;
      qph   <= 2'h0;
      cur   <= '0;
    end else begin
      state <= next_state;
      if (state == NST_IDLE) qph <= 2'h0;
      else qph <= qph + 2'h1;
      if (f_take) cur <= f_data;
    end
  end

  // memory requests: swap reads in phase 1, table read in 2nd cycle phase 1
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmem_rd        <= 1'b0;
      dmem_addr      <= '0;
      pmem_rd        <= 1'b0;
      pmem_word_addr <= '0;
    end else begin
      dmem_rd <= (state == NST_EXEC) && is_swap && (qph == 2'h0);
      if (state == NST_EXEC && is_swap) dmem_addr <= res_addr;
      pmem_rd <= (state == NST_TBL2) && is_table_read_op && (qph == 2'h0);
      if (state == NST_TBL2) pmem_word_addr <= acc_ptr[NST_PW-1:1];
    end
  end

  // swap result write in last phase; no flags are touched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmem_wr    <= 1'b0;
      dmem_wdata <= NST_BYTE_RST;
      wreg_wr    <= 1'b0;
      wreg_wdata <= NST_BYTE_RST;
    end else begin
      dmem_wr <= (state == NST_EXEC) && is_swap && (qph == 2'h2) && to_file;
      wreg_wr <= (state == NST_EXEC) && is_swap && (qph == 2'h2) && !to_file;
      if (state == NST_EXEC && is_swap && qph == 2'h2) begin
        dmem_wdata <= swapped;
        wreg_wdata <= swapped;
      end
    end
  end

  // table pointer, latch and holding registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      table_pointer <= NST_PTR_RST;
      table_latch   <= NST_BYTE_RST;
    end else begin
      if (state == NST_TBL2 && qph == 2'h2 && is_table_read_op) begin
        table_latch <= pm_byte;
      end
      if (state == NST_TBL2 && q_end) begin
        table_pointer <= next_ptr;
      end
    end
  end

  // eight holding registers, written only by table write
  for (genvar g = 0; g < NST_HOLD_N; g++) begin : g_hold
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        hold_regs[g*8 +: 8] <= NST_HOLD_RST;
      end else if (state == NST_TBL2 && q_end && is_tblwr && hold_sel == 3'(g)) begin
        hold_regs[g*8 +: 8] <= table_latch;
      end
    end
  end

  // status outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy       <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      busy       <= (next_state != NST_IDLE) && (next_state != NST_DONE);
      instr_done <= (next_state == NST_DONE);
    end
  end

  // second-cycle marker for checks
  assign cyc2 = (state == NST_TBL2);

  // swap completes in one instruction cycle
  chk_swap_one_cycle : assert property (@(posedge core_clk) disable iff (!nrst)
    (state == NST_EXEC && is_swap && qph == 2'h0) |-> ##4 (state == NST_DONE))
    else $error("swap did not finish in one cycle");
  // swap data is nibble exchange of read byte
  chk_swap_data : assert property (@(posedge core_clk) disable iff (!nrst)
    (state == NST_EXEC && is_swap && qph == 2'h2) |=>
      (dmem_wdata == {$past(dmem_rdata[3:0]), $past(dmem_rdata[7:4])}))
    else $error("swap data wrong");
  // destination exclusive
  chk_swap_dest : assert property (@(posedge core_clk) disable iff (!nrst)
    (!(dmem_wr && wreg_wr)) and
    ((state == NST_EXEC && is_swap && qph == 2'h2) |=>
      ((dmem_wr == $past(cur[NST_D_BIT])) && (wreg_wr != $past(cur[NST_D_BIT])))))
    else $error("swap wrote both destinations");
  // table op spends two instruction cycles
  chk_tbl_two_cyc : assert property (@(posedge core_clk) disable iff (!nrst)
    (state == NST_EXEC && is_tbl && qph == 2'h0) |-> ##4 cyc2 ##4 (state == NST_DONE))
    else $error("table op length wrong");
  // no program memory read for table write
  chk_tblwr_nord : assert property (@(posedge core_clk) disable iff (!nrst)
    (cyc2 && is_tblwr) |-> !pmem_rd)
    else $error("table write read program memory");
  // post increment moves pointer by one
  chk_ptr_postinc : assert property (@(posedge core_clk) disable iff (!nrst)
    (cyc2 && q_end && mode == NST_M_POSTINC) |=>
      (table_pointer == $past(table_pointer) + 21'h000001))
    else $error("post increment wrong");
  // pointer only moves at end of table op
  chk_ptr_stable : assert property (@(posedge core_clk) disable iff (!nrst)
    !(cyc2 && q_end) |=> $stable(table_pointer))
    else $error("pointer moved unexpectedly");
  // byte select follows pointer bit zero
  chk_byte_sel : assert property (@(posedge core_clk) disable iff (!nrst)
    (cyc2 && is_table_read_op && qph == 2'h2) |=>
      (table_latch == ($past(acc_ptr[0]) ? $past(pmem_rdata[15:8])
                                         : $past(pmem_rdata[7:0]))))
    else $error("wrong byte latched");
endmodule // nst_exec

/* File: bench/nst_mem_model.sv */
// data memory and program memory seen from the execution block
// assumes requests are single-clock pulses answered one clock later
module nst_mem_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // data memory read port
  input  wire logic        dmem_rd,
  input  wire logic [11:0] dmem_addr,
  output logic [7:0]       dmem_rdata,
  // program memory read port
  input  wire logic        pmem_rd,
  input  wire logic [19:0] pmem_word_addr,
  output logic [15:0]      pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pm_age;  // clocks since the last program read
  // answer one clock late; stale data is inverted each clock, program data only after a four-clock hold window
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmem_rdata <= 8'h00;
      pmem_rdata <= 16'h0000;
      pm_age     <= 2'h3;
    end else begin
      dmem_rdata <= dmem_rd ? dmem_addr[7:0] ^ {2{dmem_addr[11:8]}} ^ 8'h3C : ~dmem_rdata;
      if (pmem_rd) begin
        pmem_rdata <= {pmem_word_addr[7:0] ^ 8'h96, pmem_word_addr[7:0]};
        pm_age     <= 2'h0;
      end else if (pm_age < 2'h3) begin
        pm_age <= pm_age + 2'h1;  // hold window
      end else begin
        pmem_rdata <= ~pmem_rdata;  // released
      end
    end
  end
endmodule // nst_mem_model

/* File: bench/tb_top.sv */
// self-checking bench for the execution block
// assumes the memory model answers the design's read pulses
module tb_top
  import nst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, instr_valid, instr_ready, ext_set_en, dmem_rd, dmem_wr;
  logic wreg_wr, pmem_rd, busy, instr_done;
  logic [15:0]  instr_word, pmem_rdata;
  logic [3:0]   bank_select_reg;
  logic [11:0]  index_ptr, dmem_addr, m_a;
  logic [7:0]   dmem_rdata, dmem_wdata, wreg_wdata, table_latch, latch, m_d, m_cnt;
  logic [19:0]  pmem_word_addr;
  logic [20:0]  table_pointer, ptr;
  logic [63:0]  hold_regs, hold;
  logic         m_dw = 0, m_ww = 0, m_pr = 0, saw_full = 0;
  logic [7:0]   m_busy = 8'h00;  // busy clocks seen for the running instruction
  int           busy_q[$];       // expected busy clocks, four per instruction cycle
  logic [123:0] exp_q[$];  // notes of expected results, oldest first
  int           err_count = 0, num_checks = 0;
  nst_exec u_dut (.core_clk, .nrst, .instr_valid, .instr_ready, .instr_word, .bank_select_reg,
    .ext_set_en, .index_ptr, .dmem_rd, .dmem_addr, .dmem_rdata, .dmem_wr, .dmem_wdata,
    .wreg_wr, .wreg_wdata, .pmem_rd, .pmem_word_addr, .pmem_rdata, .table_pointer,
    .table_latch, .hold_regs, .busy, .instr_done);
  nst_mem_model u_mem (.core_clk, .nrst, .dmem_rd, .dmem_addr, .dmem_rdata, .pmem_rd,
    .pmem_word_addr, .pmem_rdata);
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cmp_obs(string n, logic [123:0] e, logic [123:0] g);
    num_checks++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_val(string n, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // offer a word and hold it until the edge that takes it
  task automatic send(logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    do @(posedge core_clk); while (instr_ready !== 1'b1);
  endtask
  // release the stream and wait, bounded, until every note is answered
  task automatic settle;
    instr_valid <= 1'b0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk);
  endtask
  task automatic cfg(logic [3:0] b, logic e, logic [11:0] ix);
    bank_select_reg <= b;
    ext_set_en      <= e;
    index_ptr       <= ix;
    @(posedge core_clk);
  endtask
  // swap: lat 0 means latency is not judged (queued words)
  task automatic do_swap(logic d, logic a, logic [7:0] f, logic [7:0] lat);
    logic [11:0] ad;
    logic [7:0]  v;
    ad = a ? {bank_select_reg, f} : (ext_set_en && f <= NST_IDX_LIMIT) ? index_ptr + {4'h0, f}
       : {(f <= NST_IDX_LIMIT) ? 4'h0 : NST_ACC_HI_BANK, f};
    v = ad[7:0] ^ {2{ad[11:8]}} ^ 8'h3C;
    exp_q.push_back({d, !d, 1'b0, ad, v[3:0], v[7:4], ptr, latch, hold, lat});
    busy_q.push_back(4);
    send({NST_SWAP_OP, d, a, f});
  endtask
  // table read or write with pointer mode m
  task automatic do_tbl(logic wr, logic [1:0] m);
    logic [20:0] acc;
    logic [15:0] pw;
    acc = (m == NST_M_PREINC) ? ptr + 21'h1 : ptr;
    pw  = {acc[8:1] ^ 8'h96, acc[8:1]};
    if (wr) hold[acc[2:0]*8 +: 8] = latch;
    else latch = acc[0] ? pw[15:8] : pw[7:0];
    ptr = (m == NST_M_POSTINC) ? acc + 21'h1 : (m == NST_M_POSTDEC) ? acc - 21'h1 : acc;
    exp_q.push_back({2'b00, !wr, 12'h000, 8'h00, ptr, latch, hold, 8'h0A});
    busy_q.push_back(8);
    send({12'h000, 1'b1, wr, m});
  endtask
  // watch the outputs and judge each completion against the oldest note
  always @(posedge core_clk) begin
    logic [123:0] e;
    if (nrst && instr_valid && !instr_ready) saw_full = 1'b1;
    if (dmem_rd) m_a = dmem_addr;
    if (dmem_wr) begin
      m_dw = 1'b1;
      m_d  = dmem_wdata;
    end
    if (wreg_wr) begin
      m_ww = 1'b1;
      m_d  = wreg_wdata;
    end
    if (pmem_rd) m_pr = 1'b1;
    if (instr_done === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      cmp_obs("result", e, {m_dw, m_ww, m_pr, m_a, m_d, table_pointer, table_latch,
        hold_regs, (e[7:0] == 8'h00) ? 8'h00 : m_cnt});
      cmp_val("busy clocks", 64'(busy_q.pop_front()), 64'(m_busy));
      {m_dw, m_ww, m_pr, m_a, m_d} = '0;
      m_busy = 8'h00;
    end else if (instr_done === 1'b1) begin
      cmp_val("unexpected done", 64'h0, 64'h1);
    end
    if (busy === 1'b1) m_busy = m_busy + 8'h01;
    m_cnt = m_cnt + 8'h01;
    if (instr_valid && instr_ready) m_cnt = 8'h01;
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    bank_select_reg = 4'h0;
    ext_set_en = 1'b0;
    index_ptr = 12'h000;
    m_cnt = 8'h00;
    {m_a, m_d} = '0;
    ptr = NST_PTR_RST;
    latch = NST_BYTE_RST;
    hold = {8{NST_HOLD_RST}};
    void'($urandom(32'h530DA6F0));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    cmp_val("hold reset", hold, hold_regs);
    cfg(4'hA, 1'b0, 12'hFF0);
    do_swap(1'b1, 1'b1, 8'h53, 8'h06);
    settle();
    do_swap(1'b0, 1'b0, 8'h5F, 8'h06);
    settle();
    do_swap(1'b1, 1'b0, 8'h60, 8'h06);
    settle();
    cfg(4'h3, 1'b1, 12'hFF0);
    do_swap(1'b0, 1'b0, 8'h5F, 8'h06);
    settle();
    do_swap(1'b1, 1'b0, 8'h60, 8'h06);
    settle();
    do_swap(1'b0, 1'b1, 8'h10, 8'h06);
    settle();
    do_tbl(1'b0, NST_M_POSTDEC);
    settle();
    do_tbl(1'b0, NST_M_PREINC);
    settle();
    for (int i = 0; i < 20; i++) begin
      do_tbl(1'($urandom), 2'($urandom));
      settle();
    end
    cfg(4'($urandom), 1'($urandom), 12'($urandom));
    for (int i = 0; i < 24; i++) do_swap(1'($urandom), 1'($urandom), 8'($urandom), 8'h00);
    settle();
    cmp_val("fifo refused", 64'h1, {63'h0, saw_full});
    cmp_val("pending notes", 64'h0, 64'(exp_q.size()));
    test_done();
  end
endmodule // tb_top
